// ---- core/batp_core.sv ----
// Address translation and incoming request protection core
//
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// R1: 32-bit addresses translated via 4k descriptor table
// R2: Four window sizes set pass-through bits
// R3: Offset 12/14/16/19 low bits from host
// R4: Per-stream 32-entry cache, fetch on miss
// R5: Descriptor 63:48 gives destination node
// R6: Prefetch 64/128 bytes, else 1-8 bytes
// R7: Reads need bit 10, writes bit 9
// R8: Lock bit makes fetch-add; writes set 47
// R9: Order, dmove, gather, hold flags drive request
// R10: Bit 2 selects large chopped packets
// R11: Reserved bit 1 ignored on reads
// R12: Odd parity generated on write, checked on read
// R13: Wide mode node from address 61:46
// R14: Wide mode stream from address 45:42
// R15: Wide address 41 forces 47:41 ones/zeros
// R16: Wide mode copies address 40:0
// R17: Wide attributes from registers, no locks, ordering
// R18: Source check all incoming; error if response expected
// R19: Permission table indexed by source 11:4
// R20: Override window bypasses source check
// R21: Read/write and read-only 16MB windows checked
// R22: No window check for I/O, software packets
// R23: Parity error sets flag, request dropped
module batp_core (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// Avalon-MM register slave
	input wire logic [batp_pkg::BUS_AW-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// Outgoing host request
	input wire logic i_req_valid,
	output logic o_req_ready,
	input wire logic [63:0] i_req_addr,
	input wire logic i_req_wide,
	input wire logic i_req_write,
	input wire logic i_req_dma,
	input wire logic [batp_pkg::STREAM_W-1:0] i_req_stream,
	output logic o_req_err,
	// Translated interconnect request
	output logic o_tx_valid,
	input wire logic i_tx_ready,
	output logic [15:0] o_tx_node,
	output logic [47:0] o_tx_offset,
	output logic o_tx_write,
	output logic o_tx_lock,
	output logic [7:0] o_tx_len,
	output logic o_tx_order,
	output logic o_tx_dmove,
	output logic o_tx_gather,
	output logic o_tx_hold,
	output logic o_tx_large,
	output logic [batp_pkg::STREAM_W-1:0] o_tx_stream,
	// Incoming request check
	input wire logic i_in_valid,
	input wire logic [15:0] i_in_src,
	input wire logic [47:0] i_in_addr,
	input wire logic i_in_write,
	input wire logic i_in_io,
	input wire logic i_in_swpkt,
	input wire logic i_in_resp_exp,
	output logic o_in_done,
	output logic o_in_accept,
	output logic o_in_addr_err
);
	function automatic logic [5:0] offb_of(input logic [1:0] wsz);
		case (wsz)
			2'd0: offb_of = batp_pkg::OFFB_16M;
			2'd1: offb_of = batp_pkg::OFFB_64M;
			2'd2: offb_of = batp_pkg::OFFB_256M;
			default: offb_of = batp_pkg::OFFB_2G;
		endcase
	endfunction

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				old[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		be_merge = old;
	endfunction

	batp_pkg::batp_state_e state_reg;
	logic bus_ack_reg;
	logic [31:0] rdata_reg;
	logic [31:0] ctrl_reg;
	logic par_err_reg;
	logic [11:0] wpio_reg;
	logic [11:0] wdma_reg;
	logic [19:0] ovr_start_reg;
	logic [19:0] ovr_end_reg;
	logic [31:0] winp_reg;
	logic [11:0] tbl_idx_reg;
	logic [31:0] tbl_lo_reg;
	logic [31:0] tbl_hi_reg;
	logic tbl_rd_pend_reg;
	logic [255:0] perm_reg;
	logic [7:0] perm_idx_reg;
	logic [63:0] req_addr_reg;
	logic req_wide_reg;
	logic req_write_reg;
	logic req_dma_reg;
	logic [batp_pkg::STREAM_W-1:0] req_stream_reg;
	logic [11:0] req_idx_reg;
	logic [batp_pkg::CACHE_N-1:0] cache_valid_reg;
	logic [11:0] cache_tag_reg [batp_pkg::CACHE_N];
	logic [63:0] cache_desc_reg [batp_pkg::CACHE_N];
	logic req_err_reg;
	logic [15:0] tx_node_reg;
	logic [47:0] tx_off_reg;
	logic tx_write_reg;
	logic tx_lock_reg;
	logic [7:0] tx_len_reg;
	logic [4:0] tx_flags_reg;
	logic [batp_pkg::STREAM_W-1:0] tx_stream_reg;
	logic in_done_reg;
	logic in_accept_reg;
	logic in_err_reg;

	logic bus_req;
	logic wr_acc;
	logic tbl_busy;
	logic ram_we;
	logic [11:0] ram_addr;
	logic [63:0] ram_wdata;
	logic [63:0] ram_rdata;
	logic par_en;
	logic hit;
	logic [63:0] eff_desc;
	logic [5:0] offb;
	logic [47:0] off_mask;
	logic [47:0] eff_off;
	logic [7:0] eff_len;
	logic eff_allowed;
	logic fetch_par_bad;
	logic ovr_hit;
	logic src_ok;
	logic win_ok;
	logic [7:0] in_page;

	// Avalon-MM slave: every access answers one cycle after it is raised
	assign bus_req = i_avs_read | i_avs_write;
	assign o_avs_waitrequest = bus_req & ~bus_ack_reg;
	assign wr_acc = i_avs_write & bus_ack_reg;
	assign o_avs_readdata = rdata_reg;
	assign par_en = ctrl_reg[batp_pkg::CTL_PAR_EN];
	assign offb = offb_of(ctrl_reg[batp_pkg::CTL_WSZ_LSB +: 2]);

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			bus_ack_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			bus_ack_reg <= bus_req & ~bus_ack_reg;
			if (i_avs_read & ~bus_ack_reg) begin
				case (i_avs_address)
					batp_pkg::OFS_CTRL: rdata_reg <= ctrl_reg;
					batp_pkg::OFS_STATUS: rdata_reg <= {31'h0, par_err_reg};
					batp_pkg::OFS_WPIO: rdata_reg <= {20'h0, wpio_reg};
					batp_pkg::OFS_WDMA: rdata_reg <= {20'h0, wdma_reg};
					batp_pkg::OFS_OVR_START: rdata_reg <= {ovr_start_reg, 12'h0};
					batp_pkg::OFS_OVR_END: rdata_reg <= {ovr_end_reg, 12'h0};
					batp_pkg::OFS_WINP: rdata_reg <= winp_reg;
					batp_pkg::OFS_TBL_IDX: rdata_reg <= {20'h0, tbl_idx_reg};
					batp_pkg::OFS_TBL_LO: rdata_reg <= tbl_lo_reg;
					batp_pkg::OFS_TBL_HI: rdata_reg <= tbl_hi_reg;
					batp_pkg::OFS_PERM: rdata_reg <= {23'h0, perm_reg[perm_idx_reg], perm_idx_reg};
					default: rdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Software registers
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctrl_reg <= batp_pkg::CTRL_RESET;
			wpio_reg <= 12'h000;
			wdma_reg <= 12'h000;
			ovr_start_reg <= batp_pkg::OVR_START_RESET;
			ovr_end_reg <= batp_pkg::OVR_END_RESET;
			winp_reg <= batp_pkg::WINP_RESET;
			tbl_idx_reg <= 12'h000;
			perm_reg <= batp_pkg::PERM_RESET;
			perm_idx_reg <= 8'h00;
		end else if (wr_acc) begin
			case (i_avs_address)
				batp_pkg::OFS_CTRL: ctrl_reg <= be_merge(ctrl_reg, i_avs_writedata, i_avs_byteenable) & 32'h0000_000F;
				batp_pkg::OFS_WPIO: wpio_reg <= i_avs_writedata[11:0];
				batp_pkg::OFS_WDMA: wdma_reg <= i_avs_writedata[11:0];
				batp_pkg::OFS_OVR_START: ovr_start_reg <= i_avs_writedata[31:12];
				batp_pkg::OFS_OVR_END: ovr_end_reg <= i_avs_writedata[31:12];
				batp_pkg::OFS_WINP: winp_reg <= be_merge(winp_reg, i_avs_writedata, i_avs_byteenable);
				batp_pkg::OFS_TBL_IDX: tbl_idx_reg <= i_avs_writedata[11:0];
				batp_pkg::OFS_PERM: begin
					perm_reg[i_avs_writedata[7:0]] <= i_avs_writedata[batp_pkg::PERM_BIT];
					perm_idx_reg <= i_avs_writedata[7:0];
				end
				default: ;
			endcase
		end
	end

	// Table port: bus commands take priority over a cache fill
	assign tbl_busy = wr_acc && (i_avs_address == batp_pkg::OFS_TBL_CMD)
		&& (i_avs_writedata[batp_pkg::CMD_WR] | i_avs_writedata[batp_pkg::CMD_RD]);
	assign ram_we = tbl_busy & i_avs_writedata[batp_pkg::CMD_WR]; // R1
	assign ram_addr = tbl_busy ? tbl_idx_reg : req_idx_reg;
	// Parity bit makes the whole word odd, or keeps software's bit when disabled
	assign ram_wdata = {tbl_hi_reg, tbl_lo_reg[31:1], par_en ? ~^{tbl_hi_reg, tbl_lo_reg[31:1]} : tbl_lo_reg[0]}; // R12
	assign fetch_par_bad = par_en & ~^ram_rdata; // R12

	batp_desc_ram #(
		.DEPTH(batp_pkg::TBL_DEPTH),
		.IDX_W(batp_pkg::TBL_IDX_W),
		.DATA_W(batp_pkg::DESC_W)
	) u_table (
		.i_ref_clk(i_ref_clk),
		.i_we(ram_we),
		.i_addr(ram_addr),
		.i_wdata(ram_wdata),
		.o_rdata(ram_rdata)
	);

	// Descriptor staging words and the sticky parity error flag
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tbl_lo_reg <= 32'h0000_0000;
			tbl_hi_reg <= 32'h0000_0000;
			tbl_rd_pend_reg <= 1'b0;
			par_err_reg <= 1'b0;
		end else begin
			tbl_rd_pend_reg <= tbl_busy & ~i_avs_writedata[batp_pkg::CMD_WR];
			if (tbl_rd_pend_reg) begin
				tbl_lo_reg <= ram_rdata[31:0];
				tbl_hi_reg <= ram_rdata[63:32];
			end else if (wr_acc && i_avs_address == batp_pkg::OFS_TBL_LO) begin
				tbl_lo_reg <= be_merge(tbl_lo_reg, i_avs_writedata, i_avs_byteenable);
			end else if (wr_acc && i_avs_address == batp_pkg::OFS_TBL_HI) begin
				tbl_hi_reg <= be_merge(tbl_hi_reg, i_avs_writedata, i_avs_byteenable);
			end
			// A new error wins over a clear in the same cycle
			if ((state_reg == batp_pkg::ST_FETCH || tbl_rd_pend_reg) && fetch_par_bad) begin
				par_err_reg <= 1'b1; // R23
			end else if (wr_acc && i_avs_address == batp_pkg::OFS_STATUS && i_avs_writedata[0]) begin
				par_err_reg <= 1'b0;
			end
		end
	end

	// Effective descriptor: cache, fresh fetch, or wide-mode attribute register
	assign hit = cache_valid_reg[req_stream_reg] && (cache_tag_reg[req_stream_reg] == req_idx_reg); // R4
	always_comb begin
		logic [11:0] wa;
		wa = req_dma_reg ? wdma_reg : wpio_reg; // R17
		if (req_wide_reg) begin
			eff_desc = {req_addr_reg[batp_pkg::W_NODE_LSB +: 16], 36'h0, wa[11:9], 1'b0, wa[7:0]}; // R13 R17
			eff_desc[batp_pkg::D_ORDER] = wa[7] | (ctrl_reg[batp_pkg::CTL_ORD64] & req_write_reg); // R17
		end else if (state_reg == batp_pkg::ST_FETCH) begin
			eff_desc = ram_rdata;
		end else begin
			eff_desc = cache_desc_reg[req_stream_reg];
		end
		eff_desc[batp_pkg::D_RESV] = 1'b0; // R11
	end

	assign off_mask = 48'((49'h1 << offb) - 49'h1); // R2
	always_comb begin
		if (req_wide_reg) begin
			eff_off = {{7{req_addr_reg[batp_pkg::W_CSR]}}, req_addr_reg[40:0]}; // R15 R16
		end else begin
			eff_off = ({eff_desc[47:batp_pkg::D_OFF_LSB], 12'h000} & ~off_mask) | (req_addr_reg[47:0] & off_mask); // R3
			if (eff_desc[batp_pkg::D_LOCK] && req_write_reg) begin
				eff_off[batp_pkg::LOCK_ADDR_BIT] = 1'b1; // R8
			end
		end
	end
	assign eff_len = !eff_desc[batp_pkg::D_PREFETCH] ? batp_pkg::LEN_SMALL
		: (eff_desc[batp_pkg::D_AGGR] ? batp_pkg::LEN_128 : batp_pkg::LEN_64); // R6
	assign eff_allowed = req_wide_reg | (req_write_reg ? eff_desc[batp_pkg::D_WRITE] : eff_desc[batp_pkg::D_READ]); // R7

	// Translation sequencer
	assign o_req_ready = (state_reg == batp_pkg::ST_IDLE);
	assign o_tx_valid = (state_reg == batp_pkg::ST_SEND);
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= batp_pkg::ST_IDLE;
			req_err_reg <= 1'b0;
		end else begin
			req_err_reg <= 1'b0;
			case (state_reg)
				batp_pkg::ST_IDLE: begin
					if (i_req_valid) begin
						state_reg <= batp_pkg::ST_LOOK;
					end
				end
				batp_pkg::ST_LOOK: begin
					if (req_wide_reg || hit) begin
						state_reg <= eff_allowed ? batp_pkg::ST_SEND : batp_pkg::ST_IDLE;
						req_err_reg <= ~eff_allowed; // R7
					end else if (!tbl_busy) begin
						state_reg <= batp_pkg::ST_FETCH; // R4
					end
				end
				batp_pkg::ST_FETCH: begin
					if (fetch_par_bad || !eff_allowed) begin
						state_reg <= batp_pkg::ST_IDLE; // R23
						req_err_reg <= 1'b1;
					end else begin
						state_reg <= batp_pkg::ST_SEND;
					end
				end
				batp_pkg::ST_SEND: begin
					if (i_tx_ready) begin
						state_reg <= batp_pkg::ST_IDLE;
					end
				end
				default: state_reg <= batp_pkg::ST_IDLE;
			endcase
		end
	end
	assign o_req_err = req_err_reg;

	// Request capture and translated request fields
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			req_addr_reg <= 64'h0;
			req_wide_reg <= 1'b0;
			req_write_reg <= 1'b0;
			req_dma_reg <= 1'b0;
			req_stream_reg <= '0;
			req_idx_reg <= 12'h000;
			tx_node_reg <= 16'h0000;
			tx_off_reg <= 48'h0;
			tx_write_reg <= 1'b0;
			tx_lock_reg <= 1'b0;
			tx_len_reg <= 8'h00;
			tx_flags_reg <= 5'h00;
			tx_stream_reg <= '0;
		end else if (state_reg == batp_pkg::ST_IDLE && i_req_valid) begin
			req_addr_reg <= i_req_addr;
			req_wide_reg <= i_req_wide;
			req_write_reg <= i_req_write;
			req_dma_reg <= i_req_dma;
			req_stream_reg <= i_req_wide ? {1'b0, i_req_addr[batp_pkg::W_STREAM_LSB +: 4]} : i_req_stream; // R14
			req_idx_reg <= 12'(i_req_addr[31:0] >> offb); // R1 R2
		end else if (state_reg == batp_pkg::ST_LOOK || state_reg == batp_pkg::ST_FETCH) begin
			tx_node_reg <= eff_desc[63:batp_pkg::D_NODE_LSB]; // R5 R13
			tx_off_reg <= eff_off;
			tx_write_reg <= req_write_reg;
			tx_lock_reg <= eff_desc[batp_pkg::D_LOCK]; // R8 R17
			tx_len_reg <= eff_len; // R6
			tx_flags_reg <= {eff_desc[batp_pkg::D_ORDER:batp_pkg::D_HOLD], eff_desc[batp_pkg::D_LARGE]}; // R9 R10
			tx_stream_reg <= req_stream_reg;
		end
	end
	assign o_tx_node = tx_node_reg;
	assign o_tx_offset = tx_off_reg;
	assign o_tx_write = tx_write_reg;
	assign o_tx_lock = tx_lock_reg;
	assign o_tx_len = tx_len_reg;
	assign {o_tx_order, o_tx_dmove, o_tx_gather, o_tx_hold} = tx_flags_reg[4:1]; // R9
	assign o_tx_large = tx_flags_reg[0]; // R10
	assign o_tx_stream = tx_stream_reg;

	// Per-stream cache; any table write drops every entry
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cache_valid_reg <= '0;
			for (int i = 0; i < batp_pkg::CACHE_N; i++) begin
				cache_tag_reg[i] <= 12'h000;
				cache_desc_reg[i] <= 64'h0;
			end
		end else begin
			if (state_reg == batp_pkg::ST_FETCH && !fetch_par_bad) begin
				cache_valid_reg[req_stream_reg] <= 1'b1; // R4
				cache_tag_reg[req_stream_reg] <= req_idx_reg;
				cache_desc_reg[req_stream_reg] <= ram_rdata;
			end
			if (ram_we) begin
				cache_valid_reg <= '0;
			end
		end
	end

	// Incoming protection, answered one cycle after the request
	assign in_page = i_in_addr[batp_pkg::WIN_GRAN_LSB +: 8];
	assign ovr_hit = (i_in_addr[31:batp_pkg::OVR_GRAN_LSB] >= ovr_start_reg)
		&& (i_in_addr[31:batp_pkg::OVR_GRAN_LSB] <= ovr_end_reg); // R20
	assign src_ok = perm_reg[i_in_src[11:4]] | ovr_hit; // R19 R20
	assign win_ok = i_in_io | i_in_swpkt // R22
		| ((in_page >= winp_reg[7:0]) && (in_page <= winp_reg[15:8])) // R21
		| (!i_in_write && (in_page >= winp_reg[23:16]) && (in_page <= winp_reg[31:24])); // R21
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			in_done_reg <= 1'b0;
			in_accept_reg <= 1'b0;
			in_err_reg <= 1'b0;
		end else begin
			in_done_reg <= i_in_valid;
			in_accept_reg <= i_in_valid & src_ok & win_ok; // R18
			in_err_reg <= i_in_valid & ~(src_ok & win_ok) & i_in_resp_exp; // R18 R21
		end
	end
	assign o_in_done = in_done_reg;
	assign o_in_accept = in_accept_reg;
	assign o_in_addr_err = in_err_reg;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);

	a_wide_node: assert property (o_tx_valid && req_wide_reg |-> o_tx_node == req_addr_reg[61:46]) // R13
		else $error("wide node mismatch");
	a_wide_csr: assert property (o_tx_valid && req_wide_reg |-> o_tx_offset[47:41] == {7{req_addr_reg[41]}}) // R15
		else $error("wide csr bits wrong");
	a_wide_offset: assert property (o_tx_valid && req_wide_reg |-> o_tx_offset[40:0] == req_addr_reg[40:0]) // R16
		else $error("wide offset not copied");
	a_wide_nolock: assert property (o_tx_valid && req_wide_reg |-> !o_tx_lock && o_tx_stream == {1'b0, req_addr_reg[45:42]}) // R17
		else $error("wide lock or stream wrong");
	a_desc_node: assert property (o_tx_valid && !req_wide_reg |-> o_tx_node == cache_desc_reg[req_stream_reg][63:48]) // R5
		else $error("node not from descriptor");
	a_perm_gate: assert property (o_tx_valid && !req_wide_reg |-> cache_desc_reg[req_stream_reg][req_write_reg ? 9 : 10]) // R7
		else $error("request sent without permission");
	a_lock_addr: assert property (o_tx_valid && o_tx_lock && o_tx_write |-> o_tx_offset[47]) // R8
		else $error("lock write missing bit 47");
	a_fetch_len: assert property (o_tx_valid && !req_wide_reg |-> o_tx_len == (!cache_desc_reg[req_stream_reg][11] ? 8'h08 : (cache_desc_reg[req_stream_reg][3] ? 8'h80 : 8'h40))) // R6
		else $error("wrong transfer length");
	a_parity_drop: assert property (state_reg == batp_pkg::ST_FETCH && fetch_par_bad |=> par_err_reg && o_req_err && !o_tx_valid) // R23
		else $error("parity error not flagged");
	a_src_reject: assert property (i_in_valid && !perm_reg[i_in_src[11:4]] && !ovr_hit |=> o_in_done && !o_in_accept && (o_in_addr_err == $past(i_in_resp_exp))) // R18
		else $error("bad source accepted");
	a_miss_bound: assert property (state_reg == batp_pkg::ST_LOOK |-> ##[1:3] state_reg != batp_pkg::ST_LOOK) // R4
		else $error("lookup stalled");

	c_wide_send: cover property (o_tx_valid && req_wide_reg && i_tx_ready);
	c_miss_fill: cover property (state_reg == batp_pkg::ST_FETCH ##1 o_tx_valid);
	c_parity_err: cover property (state_reg == batp_pkg::ST_FETCH && fetch_par_bad);
	c_src_reject: cover property (o_in_done && o_in_addr_err);
endmodule
`default_nettype wire

// ---- core/batp_desc_ram.sv ----
// Descriptor table memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module batp_desc_ram #(
	parameter int unsigned DEPTH = batp_pkg::TBL_DEPTH,
	parameter int unsigned IDX_W = batp_pkg::TBL_IDX_W,
	parameter int unsigned DATA_W = batp_pkg::DESC_W
) (
	// Clock
	input wire logic i_ref_clk,
	// Port
	input wire logic i_we,
	input wire logic [IDX_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	output logic [DATA_W-1:0] o_rdata
);
	logic [DATA_W-1:0] mem [DEPTH];

	always_ff @(posedge i_ref_clk) begin
		if (i_we) begin
			mem[i_addr] <= i_wdata;
		end
		o_rdata <= mem[i_addr];
	end
endmodule
`default_nettype wire

// ---- core/batp_pkg.sv ----
// Shared constants and types for the address translation and protection core
package batp_pkg;
	// Register byte offsets on the Avalon-MM slave
	localparam int unsigned BUS_AW = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_WPIO = 8'h08;
	localparam logic [7:0] OFS_WDMA = 8'h0C;
	localparam logic [7:0] OFS_OVR_START = 8'h10;
	localparam logic [7:0] OFS_OVR_END = 8'h14;
	localparam logic [7:0] OFS_WINP = 8'h18;
	localparam logic [7:0] OFS_TBL_IDX = 8'h1C;
	localparam logic [7:0] OFS_TBL_LO = 8'h20;
	localparam logic [7:0] OFS_TBL_HI = 8'h24;
	localparam logic [7:0] OFS_TBL_CMD = 8'h28;
	localparam logic [7:0] OFS_PERM = 8'h2C;
	// misc_control fields
	localparam int unsigned CTL_PAR_EN = 0;
	localparam int unsigned CTL_ORD64 = 1;
	localparam int unsigned CTL_WSZ_LSB = 2;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	// Table command bits
	localparam int unsigned CMD_WR = 0;
	localparam int unsigned CMD_RD = 1;
	// Permission register: index in 7:0, permit bit at 8
	localparam int unsigned PERM_BIT = 8;
	localparam logic [255:0] PERM_RESET = {256{1'b1}};
	// Window reset values: override window empty, read/write window covers 4 GB
	localparam logic [19:0] OVR_START_RESET = 20'hFFFFF;
	localparam logic [19:0] OVR_END_RESET = 20'h00000;
	localparam logic [31:0] WINP_RESET = 32'h0000_FF00;
	// Table and cache geometry
	localparam int unsigned TBL_DEPTH = 4096;
	localparam int unsigned TBL_IDX_W = 12;
	localparam int unsigned DESC_W = 64;
	localparam int unsigned CACHE_N = 32;
	localparam int unsigned STREAM_W = 5;
	// Page descriptor fields
	localparam int unsigned D_NODE_LSB = 48;
	localparam int unsigned D_OFF_LSB = 12;
	localparam int unsigned D_PREFETCH = 11;
	localparam int unsigned D_READ = 10;
	localparam int unsigned D_WRITE = 9;
	localparam int unsigned D_LOCK = 8;
	localparam int unsigned D_ORDER = 7;
	localparam int unsigned D_DMOVE = 6;
	localparam int unsigned D_GATHER = 5;
	localparam int unsigned D_HOLD = 4;
	localparam int unsigned D_AGGR = 3;
	localparam int unsigned D_LARGE = 2;
	localparam int unsigned D_RESV = 1;
	localparam int unsigned D_PAR = 0;
	localparam int unsigned LOCK_ADDR_BIT = 47;
	// Offset bits passed through per window size 16M/64M/256M/2G
	localparam logic [5:0] OFFB_16M = 6'd12;
	localparam logic [5:0] OFFB_64M = 6'd14;
	localparam logic [5:0] OFFB_256M = 6'd16;
	localparam logic [5:0] OFFB_2G = 6'd19;
	// Transfer lengths in bytes
	localparam logic [7:0] LEN_SMALL = 8'h08;
	localparam logic [7:0] LEN_64 = 8'h40;
	localparam logic [7:0] LEN_128 = 8'h80;
	// Wide address fields
	localparam int unsigned W_NODE_LSB = 46;
	localparam int unsigned W_STREAM_LSB = 42;
	localparam int unsigned W_CSR = 41;
	// Window granularities
	localparam int unsigned OVR_GRAN_LSB = 12;
	localparam int unsigned WIN_GRAN_LSB = 24;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOOK = 2'b01,
		ST_FETCH = 2'b11,
		ST_SEND = 2'b10
	} batp_state_e;
endpackage

// ---- verif/batp_far_model.sv ----
// Far interconnect node model that accepts translated requests after a set stall
`timescale 1ns/100ps
`default_nettype none
module batp_far_model (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// Request handshake
	input wire logic i_tx_valid,
	input wire logic [3:0] i_stall,
	output logic o_tx_ready
);
	logic [3:0] wait_reg;
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wait_reg <= 4'h0;
			o_tx_ready <= 1'b0;
		end else if (i_tx_valid && !o_tx_ready && wait_reg != i_stall) begin
			wait_reg <= wait_reg + 4'h1;
		end else begin
			wait_reg <= 4'h0;
			o_tx_ready <= i_tx_valid && !o_tx_ready;
		end
	end
endmodule
`default_nettype wire

// ---- verif/test_bus_addr_translate_protect.sv ----
// Self-checking bench for the address translation and protection core
`timescale 1ns/100ps
`default_nettype none
module test_bus_addr_translate_protect;
	logic clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0, q_valid = 1'b0, q_wide = 1'b0, q_write = 1'b0;
	logic in_valid = 1'b0, in_write = 1'b0, in_io = 1'b0, in_sw = 1'b0, in_resp = 1'b1;
	logic wreq, q_ready, q_err, tx_valid, tx_ready, tx_write, tx_lock, tx_order, in_done, in_acc, in_err, got_err;
	logic [7:0] addr = 8'h00, tx_len;
	logic [31:0] wdata = 32'h0, rdata, rd_word;
	logic [63:0] q_addr = 64'h0;
	logic [4:0] tx_stream;
	logic [15:0] tx_node, in_src = 16'h0;
	logic [47:0] tx_offset, in_addr = 48'h0;
	logic [3:0] stall = 4'h3;
	int fail_count = 0, samples_checked = 0;
	always #5 clk = ~clk;
	batp_core dut_u (.i_ref_clk(clk), .i_rst_b(rst_b), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wdata), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
		.i_req_valid(q_valid), .o_req_ready(q_ready), .i_req_addr(q_addr), .i_req_wide(q_wide),
		.i_req_write(q_write), .i_req_dma(1'b0), .i_req_stream(5'h00), .o_req_err(q_err), .o_tx_valid(tx_valid),
		.i_tx_ready(tx_ready), .o_tx_node(tx_node), .o_tx_offset(tx_offset), .o_tx_write(tx_write),
		.o_tx_lock(tx_lock), .o_tx_len(tx_len), .o_tx_order(tx_order), .o_tx_dmove(), .o_tx_gather(),
		.o_tx_hold(), .o_tx_large(), .o_tx_stream(tx_stream), .i_in_valid(in_valid), .i_in_src(in_src),
		.i_in_addr(in_addr), .i_in_write(in_write), .i_in_io(in_io), .i_in_swpkt(in_sw), .i_in_resp_exp(in_resp),
		.o_in_done(in_done), .o_in_accept(in_acc), .o_in_addr_err(in_err));
	batp_far_model far_u (.i_ref_clk(clk), .i_rst_b(rst_b), .i_tx_valid(tx_valid), .i_stall(stall),
		.o_tx_ready(tx_ready));
	task automatic close_out();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic stop_if(input logic hung);
		chk(64'(hung), 64'h0);
		if (hung) close_out();
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= d;
		do begin
			@(negedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 20);
		rd_word = rdata;
		@(posedge clk);
		rd <= 1'b0;
		wr <= 1'b0;
		stop_if(n >= 20);
	endtask
	task automatic host(input logic [63:0] a, input logic wide, input logic w);
		int n;
		n = 0;
		@(posedge clk);
		q_valid <= 1'b1;
		q_addr <= a;
		q_wide <= wide;
		q_write <= w;
		do begin
			@(negedge clk);
			n++;
		end while (q_ready !== 1'b1 && n < 20);
		@(posedge clk);
		q_valid <= 1'b0;
		do begin
			@(negedge clk);
			n++;
		end while (tx_valid !== 1'b1 && q_err !== 1'b1 && n < 40);
		got_err = q_err;
		stop_if(n >= 40);
	endtask
	task automatic inb(input logic [15:0] s, input logic [47:0] a, input logic w, input logic [1:0] k,
		input logic [2:0] exp);
		@(posedge clk);
		in_valid <= 1'b1;
		in_src <= s;
		in_addr <= a;
		in_write <= w;
		in_io <= k[1];
		in_sw <= k[0];
		@(posedge clk);
		in_valid <= 1'b0;
		@(negedge clk);
		chk(64'({in_done, in_acc, in_err}), 64'(exp));
	endtask
	task automatic t_regs();
		bus(1'b0, batp_pkg::OFS_CTRL, 32'h0);
		chk(64'(rd_word), 64'h1);
		bus(1'b0, batp_pkg::OFS_WINP, 32'h0);
		chk(64'(rd_word), 64'hFF00);
		bus(1'b0, 8'h3C, 32'h0);
		chk(64'(rd_word), 64'h0);
	endtask
	task automatic t_xlate();
		bus(1'b1, batp_pkg::OFS_CTRL, 32'h0);
		bus(1'b1, batp_pkg::OFS_TBL_IDX, 32'h3);
		bus(1'b1, batp_pkg::OFS_TBL_LO, 32'h5678_9C08);
		bus(1'b1, batp_pkg::OFS_TBL_HI, 32'h1234_0000);
		bus(1'b1, batp_pkg::OFS_TBL_CMD, 32'h1);
		bus(1'b1, batp_pkg::OFS_TBL_CMD, 32'h2);
		repeat (2) @(posedge clk);
		bus(1'b0, batp_pkg::OFS_TBL_LO, 32'h0);
		chk(64'(rd_word), 64'h5678_9C08);
		bus(1'b1, batp_pkg::OFS_CTRL, 32'h1);
		bus(1'b1, batp_pkg::OFS_TBL_CMD, 32'h1);
		bus(1'b1, batp_pkg::OFS_TBL_CMD, 32'h2);
		repeat (2) @(posedge clk);
		bus(1'b0, batp_pkg::OFS_TBL_LO, 32'h0);
		chk(64'(rd_word), 64'h5678_9C09);
		host(64'h3ABC, 1'b0, 1'b0);
		chk({tx_node, tx_offset}, {16'h1234, 48'h0000_5678_9ABC});
		chk(64'({got_err, tx_len, tx_lock, tx_write}), 64'({1'b0, 8'h80, 2'b00}));
		host(64'h3ABC, 1'b0, 1'b1);
		chk(64'(got_err), 64'h1);
		bus(1'b1, batp_pkg::OFS_CTRL, 32'h5);
		host(64'hEABC, 1'b0, 1'b0);
		chk({tx_node, tx_offset}, {16'h1234, 48'h0000_5678_AABC});
		// Store an entry with even parity while checking is off, then fetch it with checking on
		bus(1'b1, batp_pkg::OFS_CTRL, 32'h0);
		bus(1'b1, batp_pkg::OFS_TBL_LO, 32'h5678_9C08);
		bus(1'b1, batp_pkg::OFS_TBL_CMD, 32'h1);
		bus(1'b1, batp_pkg::OFS_CTRL, 32'h1);
		host(64'h3ABC, 1'b0, 1'b0);
		chk(64'(got_err), 64'h1);
		bus(1'b0, batp_pkg::OFS_STATUS, 32'h0);
		chk(64'(rd_word), 64'h1);
		// Lock page with write permission
		bus(1'b1, batp_pkg::OFS_TBL_LO, 32'h5678_9300);
		bus(1'b1, batp_pkg::OFS_TBL_CMD, 32'h1);
		host(64'h3ABC, 1'b0, 1'b1);
		chk({tx_node, tx_offset}, {16'h1234, 48'h8000_5678_9ABC});
		chk(64'({got_err, tx_lock, tx_len}), 64'({2'b01, 8'h08}));
	endtask
	task automatic t_wide();
		@(posedge clk);
		stall <= 4'h0;
		bus(1'b1, batp_pkg::OFS_CTRL, 32'h3);
		host({2'b00, 16'hBEEF, 4'h5, 1'b1, 41'h0_1234_5678}, 1'b1, 1'b1);
		chk({tx_node, tx_offset}, {16'hBEEF, 7'h7F, 41'h0_1234_5678});
		chk(64'({tx_stream, tx_lock, tx_order, got_err}), 64'({5'h05, 3'b010}));
		host({2'b00, 16'h0102, 4'h9, 1'b0, 41'h1_0000_00FF}, 1'b1, 1'b0);
		chk({tx_node, tx_offset}, {16'h0102, 7'h00, 41'h1_0000_00FF});
		chk(64'(tx_stream), 64'h09);
	endtask
	task automatic t_inbound();
		bus(1'b1, batp_pkg::OFS_PERM, 32'h012);
		inb(16'h0123, 48'h0, 1'b0, 2'b00, 3'b101);
		inb(16'h0123, 48'h0, 1'b0, 2'b01, 3'b101);
		inb(16'hF12A, 48'h0, 1'b0, 2'b00, 3'b101);
		inb(16'h0133, 48'h0, 1'b0, 2'b00, 3'b110);
		bus(1'b1, batp_pkg::OFS_OVR_START, 32'h0050_0000);
		bus(1'b1, batp_pkg::OFS_OVR_END, 32'h0050_0000);
		inb(16'h0123, 48'h50_0FFC, 1'b1, 2'b00, 3'b110);
		inb(16'h0123, 48'h50_1000, 1'b1, 2'b00, 3'b101);
		bus(1'b1, batp_pkg::OFS_WINP, 32'h1010_0F00);
		inb(16'h0133, 48'h0F00_0000, 1'b1, 2'b00, 3'b110);
		inb(16'h0133, 48'h1000_0000, 1'b1, 2'b00, 3'b101);
		inb(16'h0133, 48'h1000_0000, 1'b0, 2'b00, 3'b110);
		inb(16'h0133, 48'hABCD_2000_0000, 1'b0, 2'b00, 3'b101);
		inb(16'h0133, 48'hABCD_0100_0000, 1'b1, 2'b00, 3'b110);
		inb(16'h0133, 48'h2000_0000, 1'b1, 2'b10, 3'b110);
		inb(16'h0133, 48'h2000_0000, 1'b1, 2'b01, 3'b110);
		@(posedge clk);
		in_resp <= 1'b0;
		inb(16'h0123, 48'h0, 1'b0, 2'b00, 3'b100);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		t_xlate();
		t_wide();
		t_inbound();
		close_out();
	end
endmodule
`default_nettype wire
